// ---- rtl/csw_pkg.sv ----
// Constants shared by the commutation and current limit configuration block.
// Assumes an 8-bit register address on a plain strobe port and 32-bit data.
package csw_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0]  CSW_OFS_CFG       = 8'h88;          // Limit and method config.
   localparam logic [7:0]  CSW_OFS_TUNING    = 8'h8a;          // Switchover tuning.
   localparam logic [7:0]  CSW_OFS_STATUS    = 8'h8b;          // Read-only live state.
   localparam logic [31:0] CSW_RST_CFG       = 32'h0000_0000;  // Config value after reset.
   localparam logic [31:0] CSW_RST_TUNING    = 32'h0000_00a0;  // Tuning value after reset.

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CSW_POS_METHOD      = 0;   // Commutation method bit.
   localparam int CSW_POS_OL_SRC      = 1;   // Open-loop limit source bit.
   localparam int CSW_POS_RUN_LSB     = 2;   // Run limit code, bits 6..2.
   localparam int CSW_POS_RISE_LSB    = 11;  // Rising back-EMF limit, bits 16..11.
   localparam int CSW_POS_FALL_LSB    = 17;  // Falling back-EMF limit, bits 22..17.
   localparam int CSW_POS_DUTY_HI_LSB = 23;  // Duty high threshold, bits 24..23.
   localparam int CSW_POS_DUTY_LO_LSB = 25;  // Duty low threshold, bits 26..25.
   localparam int CSW_POS_SMP_HI_LSB  = 27;  // Sample high threshold, bits 28..27.
   localparam int CSW_POS_SMP_LO_LSB  = 29;  // Sample low threshold, bits 30..29.
   localparam int CSW_POS_STAT_MA_LSB = 16;  // Run limit in mA inside status.

   // ------------------------------------------------------------------
   // Run limit arithmetic
   // ------------------------------------------------------------------
   localparam logic [15:0] CSW_MV_PER_CODE   = 16'd100;   // 0.1 V per code step.
   localparam logic [15:0] CSW_UNI_OFFSET_MV = 16'd75;    // Unidirectional offset.
   localparam logic [4:0]  CSW_UNI_WRAP      = 5'h1b;     // Unidirectional wrap point.
   localparam logic [4:0]  CSW_BI_MASK       = 5'h0f;     // Bidirectional wrap mask.
   localparam logic [31:0] CSW_MA_PER_A      = 32'd1000;  // Milliamps per amp.

   // Sense amplifier gain codes and their gains in V/V.
   localparam logic [7:0]  CSW_GAIN_0        = 8'd5;
   localparam logic [7:0]  CSW_GAIN_1        = 8'd10;
   localparam logic [7:0]  CSW_GAIN_2        = 8'd20;
   localparam logic [7:0]  CSW_GAIN_3        = 8'd40;

   // ------------------------------------------------------------------
   // Switchover threshold tables
   // ------------------------------------------------------------------
   localparam logic [7:0]  CSW_SMP_LO_0 = 8'd3;
   localparam logic [7:0]  CSW_SMP_LO_1 = 8'd4;
   localparam logic [7:0]  CSW_SMP_LO_2 = 8'd6;
   localparam logic [7:0]  CSW_SMP_LO_3 = 8'd8;
   localparam logic [7:0]  CSW_SMP_HI_0 = 8'd4;
   localparam logic [7:0]  CSW_SMP_HI_1 = 8'd6;
   localparam logic [7:0]  CSW_SMP_HI_2 = 8'd8;
   localparam logic [7:0]  CSW_SMP_HI_3 = 8'd10;
   localparam logic [6:0]  CSW_DUTY_0   = 7'd12;
   localparam logic [6:0]  CSW_DUTY_1   = 7'd15;
   localparam logic [6:0]  CSW_DUTY_2   = 7'd18;
   localparam logic [6:0]  CSW_DUTY_3   = 7'd20;

   // Back-EMF limit segments: fine step, then coarser steps.
   localparam logic [11:0] CSW_BEMF_STEP0 = 12'd25;
   localparam logic [11:0] CSW_BEMF_STEP1 = 12'd50;
   localparam logic [11:0] CSW_BEMF_STEP2 = 12'd100;
   localparam logic [11:0] CSW_BEMF_STEP3 = 12'd200;
   localparam logic [5:0]  CSW_BEMF_SEG1  = 6'h20;
   localparam logic [5:0]  CSW_BEMF_SEG2  = 6'h30;
   localparam logic [5:0]  CSW_BEMF_SEG3  = 6'h39;
   localparam logic [11:0] CSW_BEMF_BASE1 = 12'd800;
   localparam logic [11:0] CSW_BEMF_BASE2 = 12'd1600;
   localparam logic [11:0] CSW_BEMF_BASE3 = 12'd2600;

   // Commutation modes.
   typedef enum logic [0:0] {
      CSW_ZC    = 1'b0,
      CSW_INTEG = 1'b1
   } csw_mode_e;

endpackage

// ---- rtl/csw_commutation_switch_config.sv ----
// Commutation method, switchover and run current limit configuration.
// Assumes synchronous inputs on ref_clk and a master on the plain register port.
module csw_commutation_switch_config
   import csw_pkg::*;
(
   input  wire logic        ref_clk,                  // System clock, 100 MHz.
   input  wire logic        nrst,                     // Asynchronous reset, active low.
   input  wire logic [7:0]  reg_addr,                 // Register address.
   input  wire logic [31:0] reg_wdata,                // Register write data.
   input  wire logic        reg_wr,                   // Write strobe.
   input  wire logic        reg_rd,                   // Read strobe.
   output logic      [31:0] reg_rdata,                // Read data, cycle after strobe.
   input  wire logic        bi_dir_sense,             // High for bidirectional sensing.
   input  wire logic [1:0]  sense_amp_gain,           // Gain code: 5, 10, 20, 40 V/V.
   input  wire logic [15:0] shunt_resistance,         // Shunt in milliohms.
   input  wire logic [4:0]  open_loop_limit_code,     // Dedicated open-loop code.
   input  wire logic [7:0]  bemf_samples,             // Back-EMF samples per 30 deg.
   input  wire logic [6:0]  drive_duty,               // Drive duty in percent.
   output logic      [15:0] run_limit_mv,             // Run limit voltage in mV.
   output logic      [31:0] run_limit_ma,             // Run limit current in mA.
   output logic             run_code_invalid,         // Code at or above 1Bh.
   output logic      [4:0]  open_loop_active_code,    // Code used in open loop.
   output logic             integ_active,             // High while integrating.
   output logic      [11:0] falling_backemf_limit,    // Falling threshold value.
   output logic      [11:0] rising_backemf_limit      // Rising threshold value.
);

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------

   // Decodes a six-bit back-EMF code into its threshold value.
   function automatic logic [11:0] bemf_decode(input logic [5:0] code);
      logic [11:0] c;
      c = {6'h00, code};
      if (code < CSW_BEMF_SEG1)
         bemf_decode = 12'(c * CSW_BEMF_STEP0);
      else if (code < CSW_BEMF_SEG2)
         bemf_decode = 12'(CSW_BEMF_BASE1 + (c - 12'(CSW_BEMF_SEG1)) * CSW_BEMF_STEP1);
      else if (code < CSW_BEMF_SEG3)
         bemf_decode = 12'(CSW_BEMF_BASE2 + (c - 12'(CSW_BEMF_SEG2)) * CSW_BEMF_STEP2);
      else
         bemf_decode = 12'(CSW_BEMF_BASE3 + (c - 12'(CSW_BEMF_SEG3)) * CSW_BEMF_STEP3);
   endfunction

   // Decodes a two-bit duty threshold code into percent.
   function automatic logic [6:0] duty_decode(input logic [1:0] code);
      case (code)
         2'h0:    duty_decode = CSW_DUTY_0;
         2'h1:    duty_decode = CSW_DUTY_1;
         2'h2:    duty_decode = CSW_DUTY_2;
         default: duty_decode = CSW_DUTY_3;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Registers and derived values
   // ------------------------------------------------------------------
   logic [31:0] cfg_ff;         // Limit and method configuration.
   logic [31:0] tuning_ff;      // Switchover and back-EMF tuning.
   logic [31:0] rdata_ff;       // Read data holding flop.
   logic [15:0] mv_ff;          // Registered run voltage.
   logic [31:0] ma_ff;          // Registered run current.
   logic        invalid_ff;     // Registered invalid-code flag.
   logic [4:0]  ol_code_ff;     // Registered open-loop code.
   csw_mode_e   mode_ff;        // Current commutation mode.
   logic [11:0] fall_ff;        // Registered falling threshold.
   logic [11:0] rise_ff;        // Registered rising threshold.

   logic [4:0]  run_code;       // Raw run limit code.
   logic [4:0]  eff_code;       // Code after wrap.
   logic [15:0] nxt_mv;         // Voltage for the effective code.
   logic [31:0] nxt_ma;         // Current for that voltage.
   logic [31:0] numer;          // Milliamp numerator.
   logic [31:0] denom;          // Gain times shunt.
   logic [7:0]  gain_vv;        // Gain in V/V.
   logic [7:0]  smp_lo;         // Decoded low sample threshold.
   logic [7:0]  smp_hi;         // Decoded high sample threshold.
   logic [6:0]  duty_lo;        // Decoded low duty threshold.
   logic [6:0]  duty_hi;        // Decoded high duty threshold.
   csw_mode_e   nxt_mode;       // Next commutation mode.

   assign run_code = cfg_ff[CSW_POS_RUN_LSB +: 5];

   // ------------------------------------------------------------------
   // Register write port
   // ------------------------------------------------------------------

   // Writes land in the addressed register; other addresses are ignored.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg_ff    <= CSW_RST_CFG;
         tuning_ff <= CSW_RST_TUNING;
      end
      else if (reg_wr)
      begin
         if (reg_addr == CSW_OFS_CFG)
            cfg_ff <= reg_wdata;
         else if (reg_addr == CSW_OFS_TUNING)
            tuning_ff <= reg_wdata;
      end
   end

   // Read data stand only in the cycle after the strobe, else zero.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rdata_ff <= 32'h0000_0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            CSW_OFS_CFG:    rdata_ff <= cfg_ff;
            CSW_OFS_TUNING: rdata_ff <= tuning_ff;
            CSW_OFS_STATUS: rdata_ff <= {ma_ff[15:0], 14'h0000, invalid_ff, mode_ff};
            default:        rdata_ff <= 32'h0000_0000;  // Unmapped reads as zero.
         endcase
      end
      else
         rdata_ff <= 32'h0000_0000;
   end

   // ------------------------------------------------------------------
   // Run current limit
   // ------------------------------------------------------------------

   // Wrap the code, scale to millivolts and divide down to milliamps.
   // The divider is combinational; it is registered so timing has a full cycle.
   always_comb
   begin
      if (bi_dir_sense)
         eff_code = run_code & CSW_BI_MASK;
      else if (run_code >= CSW_UNI_WRAP)
         eff_code = 5'(run_code - CSW_UNI_WRAP);
      else
         eff_code = run_code;
      nxt_mv = 16'(eff_code * CSW_MV_PER_CODE);
      case (sense_amp_gain)
         2'h0:    gain_vv = CSW_GAIN_0;
         2'h1:    gain_vv = CSW_GAIN_1;
         2'h2:    gain_vv = CSW_GAIN_2;
         default: gain_vv = CSW_GAIN_3;
      endcase
      if (bi_dir_sense)
         numer = 32'(nxt_mv) * CSW_MA_PER_A;
      else if (nxt_mv > CSW_UNI_OFFSET_MV)
         numer = 32'(nxt_mv - CSW_UNI_OFFSET_MV) * CSW_MA_PER_A;
      else
         numer = 32'h0000_0000;
      denom = 32'(gain_vv) * 32'(shunt_resistance);
      // A zero shunt would divide by zero; saturate instead.
      if (denom == 32'h0000_0000)
         nxt_ma = 32'hffff_ffff;
      else
         nxt_ma = numer / denom;
   end

   // Register the limit results.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mv_ff      <= 16'h0000;
         ma_ff      <= 32'h0000_0000;
         invalid_ff <= 1'b0;
      end
      else
      begin
         mv_ff      <= nxt_mv;
         ma_ff      <= nxt_ma;
         invalid_ff <= (run_code >= CSW_UNI_WRAP);
      end
   end

   // Open-loop limit comes from its own code or the run code.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         ol_code_ff <= 5'h00;
      else if (cfg_ff[CSW_POS_OL_SRC])
         ol_code_ff <= run_code;
      else
         ol_code_ff <= open_loop_limit_code;
   end

   // ------------------------------------------------------------------
   // Commutation switchover
   // ------------------------------------------------------------------

   // Entering integration needs both counts high, so a mixed reading
   // cannot make the mode flip every cycle.
   always_comb
   begin
      smp_lo  = CSW_SMP_LO_0;
      smp_hi  = CSW_SMP_HI_0;
      case (tuning_ff[CSW_POS_SMP_LO_LSB +: 2])
         2'h0:    smp_lo = CSW_SMP_LO_0;
         2'h1:    smp_lo = CSW_SMP_LO_1;
         2'h2:    smp_lo = CSW_SMP_LO_2;
         default: smp_lo = CSW_SMP_LO_3;
      endcase
      case (tuning_ff[CSW_POS_SMP_HI_LSB +: 2])
         2'h0:    smp_hi = CSW_SMP_HI_0;
         2'h1:    smp_hi = CSW_SMP_HI_1;
         2'h2:    smp_hi = CSW_SMP_HI_2;
         default: smp_hi = CSW_SMP_HI_3;
      endcase
      duty_lo = duty_decode(tuning_ff[CSW_POS_DUTY_LO_LSB +: 2]);
      duty_hi = duty_decode(tuning_ff[CSW_POS_DUTY_HI_LSB +: 2]);
      nxt_mode = mode_ff;
      if (!cfg_ff[CSW_POS_METHOD])
         nxt_mode = CSW_ZC;
      else
      begin
         case (mode_ff)
            CSW_INTEG:
            begin
               if (bemf_samples < smp_lo)
                  nxt_mode = CSW_ZC;
               else if (drive_duty < duty_lo)
                  nxt_mode = CSW_ZC;
            end
            CSW_ZC:
            begin
               if (bemf_samples > smp_hi && drive_duty > duty_hi)
                  nxt_mode = CSW_INTEG;
            end
            default: nxt_mode = CSW_ZC;
         endcase
      end
   end

   // Mode flop; starts in zero-crossing.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         mode_ff <= CSW_ZC;
      else
         mode_ff <= nxt_mode;
   end

   // ------------------------------------------------------------------
   // Back-EMF integration thresholds
   // ------------------------------------------------------------------

   // Decode both phase thresholds with the same table.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fall_ff <= 12'h000;
         rise_ff <= 12'h000;
      end
      else
      begin
         fall_ff <= bemf_decode(tuning_ff[CSW_POS_FALL_LSB +: 6]);
         rise_ff <= bemf_decode(tuning_ff[CSW_POS_RISE_LSB +: 6]);
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign reg_rdata             = rdata_ff;
   assign run_limit_mv          = mv_ff;
   assign run_limit_ma          = ma_ff;
   assign run_code_invalid      = invalid_ff;
   assign open_loop_active_code = ol_code_ff;
   assign integ_active          = (mode_ff == CSW_INTEG);
   assign falling_backemf_limit = fall_ff;
   assign rising_backemf_limit  = rise_ff;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   AST_MV_TOP: assert property (@(posedge ref_clk) disable iff (!nrst)
      (run_code == 5'h1a && !bi_dir_sense) |=> (run_limit_mv == 16'd2600))
      else $error("Code 1Ah did not give 2600 mV.");

   AST_MA_UNI: assert property (@(posedge ref_clk) disable iff (!nrst)
      (run_code == 5'h0a && !bi_dir_sense && sense_amp_gain == 2'h1
       && shunt_resistance == 16'd10) |=> (run_limit_ma == 32'd9250))
      else $error("Unidirectional current limit wrong.");

   AST_MA_BI: assert property (@(posedge ref_clk) disable iff (!nrst)
      (run_code == 5'h0a && bi_dir_sense && sense_amp_gain == 2'h1
       && shunt_resistance == 16'd10) |=> (run_limit_ma == 32'd10000))
      else $error("Bidirectional current limit wrong.");

   AST_WRAP: assert property (@(posedge ref_clk) disable iff (!nrst)
      (run_code == 5'h1c && !bi_dir_sense) |=> (run_code_invalid && run_limit_mv == 16'd100))
      else $error("Unidirectional wrap wrong.");

   AST_OL_SRC: assert property (@(posedge ref_clk) disable iff (!nrst)
      1'b1 |=> (open_loop_active_code ==
                ($past(cfg_ff[1]) ? $past(run_code) : $past(open_loop_limit_code))))
      else $error("Open-loop limit source wrong.");

   AST_ZC_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
      !cfg_ff[0] |=> !integ_active)
      else $error("Integration active while zero-crossing selected.");

   AST_SMP_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
      (integ_active && cfg_ff[0] && tuning_ff[30:29] == 2'h3 && bemf_samples == 8'd7)
      |=> !integ_active)
      else $error("Low sample count did not leave integration.");

   AST_DUTY_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
      (integ_active && cfg_ff[0] && tuning_ff[26:25] == 2'h0 && drive_duty == 7'd11)
      |=> !integ_active)
      else $error("Low duty did not leave integration.");

   AST_TO_INTEG: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!integ_active && cfg_ff[0] && bemf_samples == 8'd11 && drive_duty == 7'd21)
      |=> integ_active)
      else $error("High samples and duty did not enter integration.");

   AST_FALL: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tuning_ff[22:17] == 6'h1f) |=> (falling_backemf_limit == 12'd775))
      else $error("Falling limit code 1Fh wrong.");

   AST_RISE: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tuning_ff[16:11] == 6'h01) |=> (rising_backemf_limit == 12'd25))
      else $error("Rising limit code 1h wrong.");

   // Duty equal to the high threshold must not enter integration.
   AST_DUTY_EQ: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!integ_active && tuning_ff[24:23] == 2'h3 && drive_duty == 7'd20) |=> !integ_active)
      else $error("Duty equal to high threshold entered integration.");

endmodule

// ---- dv/csw_commutation_switch_config_tb_top.sv ----
// Self-checking bench for the commutation and current limit configuration block.
// Assumes csw_pkg is compiled first and the design runs on one 100 MHz clock.
module csw_commutation_switch_config_tb_top
   import csw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Signals and expectation tables
   // ------------------------------------------------------------------
   logic        ref_clk = 1'b0;     // Bench clock.
   logic        nrst, reg_wr, reg_rd, bi_dir_sense, run_code_invalid, integ_active;
   logic [7:0]  reg_addr, bemf_samples;                  // Address and sample count.
   logic [31:0] reg_wdata, reg_rdata, run_limit_ma;      // Bus data and milliamps result.
   logic [1:0]  sense_amp_gain;                          // Gain code.
   logic [15:0] shunt_resistance, run_limit_mv;          // Shunt and millivolts result.
   logic [4:0]  open_loop_limit_code, open_loop_active_code;
   logic [6:0]  drive_duty;                              // Duty in percent.
   logic [11:0] falling_backemf_limit, rising_backemf_limit;
   int          num_errors = 0;                          // Mismatch count.
   int          tests_run  = 0;                          // Comparison count.
   int          cycles     = 0;                          // Hang guard.
   logic [7:0]  smp_lo[4] = '{8'd3, 8'd4, 8'd6, 8'd8};   // Low sample thresholds.
   logic [7:0]  smp_hi[4] = '{8'd4, 8'd6, 8'd8, 8'd10};  // High sample thresholds.
   logic [6:0]  duty[4]   = '{7'd12, 7'd15, 7'd18, 7'd20};
   typedef struct {logic bi; logic [1:0] g; logic [15:0] r; logic [4:0] code; logic src;
      logic [4:0] olc; logic [15:0] mv; logic [31:0] ma; logic inv; logic [4:0] ola;} csw_row_s;
   // Wrap rows sit beside plain ones; shunt zero must saturate, not divide by zero.
   csw_row_s    rows[7] = '{
      '{1'b0, 2'd1, 16'd10, 5'h0a, 1'b0, 5'h03, 16'd1000, 32'd9250,  1'b0, 5'h03},
      '{1'b0, 2'd1, 16'd5,  5'h1a, 1'b1, 5'h07, 16'd2600, 32'd50500, 1'b0, 5'h1a},
      '{1'b0, 2'd2, 16'd1,  5'h1c, 1'b0, 5'h1f, 16'd100,  32'd1250,  1'b1, 5'h1f},
      '{1'b1, 2'd3, 16'd2,  5'h13, 1'b0, 5'h00, 16'd300,  32'd3750,  1'b0, 5'h00},
      '{1'b0, 2'd0, 16'd1,  5'h00, 1'b0, 5'h11, 16'd0,    32'd0,     1'b0, 5'h11},
      '{1'b1, 2'd1, 16'd10, 5'h0a, 1'b1, 5'h02, 16'd1000, 32'd10000, 1'b0, 5'h0a},
      '{1'b1, 2'd0, 16'd0,  5'h1b, 1'b0, 5'h15, 16'd1100, 32'hffffffff, 1'b1, 5'h15}};

   csw_commutation_switch_config csw_commutation_switch_config_i (
      .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bi_dir_sense(bi_dir_sense),
      .sense_amp_gain(sense_amp_gain), .shunt_resistance(shunt_resistance),
      .open_loop_limit_code(open_loop_limit_code), .bemf_samples(bemf_samples),
      .drive_duty(drive_duty), .run_limit_mv(run_limit_mv), .run_limit_ma(run_limit_ma),
      .run_code_invalid(run_code_invalid), .open_loop_active_code(open_loop_active_code),
      .integ_active(integ_active), .falling_backemf_limit(falling_backemf_limit),
      .rising_backemf_limit(rising_backemf_limit));

   always #5 ref_clk = ~ref_clk;

   // ------------------------------------------------------------------
   // Compare, bus and stimulus tasks
   // ------------------------------------------------------------------
   // Register reads and port outputs are counted the same but reported apart.
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: read got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: output got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data exist only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Register, then derived outputs and mode flop, each take one edge.
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic set_motion(input logic [7:0] s, input logic [6:0] dt, input logic e);
      @(posedge ref_clk);
      bemf_samples <= s;
      drive_duty   <= dt;
      settle();
      chk_out({31'h0, integ_active}, {31'h0, e});
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hang is cut short well past the few hundred cycles the run needs.
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: run did not finish in time", $time);
         conclude();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [5:0]  fc;
      {nrst, reg_wr, reg_rd, bi_dir_sense, sense_amp_gain, reg_addr, reg_wdata} = '0;
      {shunt_resistance, open_loop_limit_code, bemf_samples, drive_duty} = '0;
      repeat (20) @(posedge ref_clk);
      chk_out({16'h0, run_limit_mv}, 32'h0);
      nrst <= 1'b1;
      rd(CSW_OFS_CFG, d);
      chk_rd(d, CSW_RST_CFG);
      rd(CSW_OFS_TUNING, d);
      chk_rd(d, CSW_RST_TUNING);
      // Table of limit settings: inputs first, then the values they must give.
      foreach (rows[i])
      begin
         @(posedge ref_clk);
         bi_dir_sense         <= rows[i].bi;
         sense_amp_gain       <= rows[i].g;
         shunt_resistance     <= rows[i].r;
         open_loop_limit_code <= rows[i].olc;
         wr(CSW_OFS_CFG, {25'h0, rows[i].code, rows[i].src, 1'b0});
         settle();
         chk_out({16'h0, run_limit_mv}, {16'h0, rows[i].mv});
         chk_out(run_limit_ma, rows[i].ma);
         chk_out({31'h0, run_code_invalid}, {31'h0, rows[i].inv});
         chk_out({27'h0, open_loop_active_code}, {27'h0, rows[i].ola});
         rd(CSW_OFS_STATUS, d);
         chk_rd(d, {rows[i].ma[15:0], 14'h0, rows[i].inv, 1'b0});
      end
      // Back-EMF limits at codes 1h and 1Fh of the 25-step range.
      for (int k = 0; k < 2; k++)
      begin
         fc = (k == 0) ? 6'h1f : 6'h01;
         wr(CSW_OFS_TUNING, {9'h0, fc, fc ^ 6'h1e, 11'h0});
         settle();
         chk_out({20'h0, falling_backemf_limit}, 32'd25 * fc);
         chk_out({20'h0, rising_backemf_limit}, 32'd25 * (fc ^ 6'h1e));
      end
      // Coarser segments above 1Fh: 3Fh falling, 20h rising.
      wr(CSW_OFS_TUNING, {9'h0, 6'h3f, 6'h20, 11'h0});
      settle();
      chk_out({20'h0, falling_backemf_limit}, 32'd3800);
      chk_out({20'h0, rising_backemf_limit}, 32'd800);
      // Every threshold code; equal values must never cause a switch.
      for (int k = 0; k < 4; k++)
      begin
         wr(CSW_OFS_TUNING, {1'b0, 2'(k), 2'(k), 2'(k), 2'(k), 23'h0});
         wr(CSW_OFS_CFG, 32'h1);
         set_motion(smp_hi[k], duty[k] + 7'd1, 1'b0);
         set_motion(smp_hi[k] + 8'd1, duty[k], 1'b0);
         set_motion(smp_hi[k] + 8'd1, duty[k] + 7'd1, 1'b1);
         set_motion(smp_lo[k], duty[k], 1'b1);
         set_motion(smp_lo[k] - 8'd1, duty[k] + 7'd1, 1'b0);
         set_motion(smp_hi[k] + 8'd1, duty[k] + 7'd1, 1'b1);
         rd(CSW_OFS_STATUS, d);
         chk_rd({31'h0, d[0]}, 32'h1);
         set_motion(smp_hi[k] + 8'd1, duty[k] - 7'd1, 1'b0);
         wr(CSW_OFS_CFG, 32'h0);
         set_motion(smp_hi[k] + 8'd1, duty[k] + 7'd1, 1'b0);
      end
      // Unmapped and read-only places leave state alone; the unmapped place reads as zero.
      wr(8'h8b, 32'hffffffff);
      wr(8'h10, 32'hffffffff);
      rd(8'h10, d);
      chk_rd(d, 32'h0);
      rd(CSW_OFS_CFG, d);
      chk_rd(d, 32'h0);
      rd(CSW_OFS_TUNING, d);
      chk_rd(d, 32'h7f80_0000);
      @(posedge ref_clk);
      #1;
      chk_rd(reg_rdata, 32'h0);
      // A reset in mid-run, taken while integrating, restores every register.
      wr(CSW_OFS_CFG, 32'h1);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk_out(run_limit_ma, 32'h0);
      chk_out({31'h0, integ_active}, 32'h0);
      chk_out({27'h0, open_loop_active_code}, 32'h0);
      @(posedge ref_clk);
      nrst <= 1'b1;
      rd(CSW_OFS_TUNING, d);
      chk_rd(d, CSW_RST_TUNING);
      rd(CSW_OFS_CFG, d);
      chk_rd(d, CSW_RST_CFG);
      conclude();
   end
endmodule
